// ### fadc_pkg.sv
// constants and carrier types shared by the flash converter back end
// assumes one clock (pclk) and an apb master on the register side
package fadc_pkg;
    localparam int NUM_COMP = 256;
    localparam int NUM_SEG = 4;
    localparam int SEG_W = 64;
    localparam int IDX_W = 6;
    localparam int CODE_W = 8;
    localparam int AIN_W = 9;

    localparam int CLK_MHZ = 25;
    localparam int LATENCY_CYC = 1;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_LAST = 8'h0C;

    localparam int CTRL_LOW_BIT = 0;
    localparam int CTRL_MSB_BIT = 1;
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    localparam int EVT_OVR_BIT = 0;
    localparam int EVT_CHG_BIT = 1;
    localparam int EVT_W = 2;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] STATUS_RST = 2'h0;

    localparam logic [7:0] LOW_INV_MASK = 8'h7F;
    localparam logic [7:0] MSB_INV_MASK = 8'h80;
    localparam logic [7:0] OVR_CODE = 8'hFF;
    localparam logic [1:0] FILL_FULL = 2'h2;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic pol;
        logic msb_inv;
        logic low_inv;
    } fadc_ctl_t;

    typedef struct packed {
        logic ovr;
        logic [CODE_W-1:0] data;
    } fadc_code_t;

    // one 7-bit column latch: segment holds ones, and its top set index
    typedef struct packed {
        logic any;
        logic [IDX_W-1:0] idx;
    } fadc_col_t;
endpackage

// ### fadc_seg_decoder.sv
// one 64-line thermometer segment reduced to a 7-bit column word
// assumes the segment is a thermometer code, lowest line at bit 0
`timescale 1ns/100ps
module fadc_seg_decoder
    import fadc_pkg::*;
(
    input wire logic [SEG_W-1:0] seg,
    output fadc_col_t col
);
    // highest set line wins, so a stray low bubble costs at most one code
    function automatic logic [IDX_W-1:0] top_set(input logic [SEG_W-1:0] v);
        logic [IDX_W-1:0] idx;
        idx = 6'h00;
        for (int j = 0; j < SEG_W; j++)
        begin
            if (v[j])
            begin
                idx = IDX_W'(j);
            end
        end
        return idx;
    endfunction

    assign col.any = |seg; // [RQ5]
    assign col.idx = top_set(seg); // [RQ5]
endmodule

// ### fadc_out_stage.sv
// output coding gates and the nine output latches
// assumes the straight code and control arrive settled before the rising edge
`timescale 1ns/100ps
module fadc_out_stage
    import fadc_pkg::*;
(
    input wire logic pclk,
    input fadc_code_t straight,
    input fadc_ctl_t ctl,
    output fadc_code_t coded_d,
    output fadc_code_t out_q
);
    logic [CODE_W-1:0] inv_mask;
    logic [CODE_W-1:0] xored;

    assign inv_mask = (ctl.low_inv ? LOW_INV_MASK : 8'h00)
                    | (ctl.msb_inv ? MSB_INV_MASK : 8'h00); // [RQ11] [RQ12]
    assign xored = straight.data ^ inv_mask; // [RQ8]
    // overrange overrides the coding so all pins read high whatever the mode
    assign coded_d.data = straight.ovr ? OVR_CODE : xored; // [RQ1]
    assign coded_d.ovr = straight.ovr; // [RQ1]

    // no reset: contents are meaningful only once the pipe is filled
    always_ff @(posedge pclk)
    begin
        out_q <= coded_d; // [RQ9] [RQ10]
    end
endmodule

// ### fadc_backend.sv
// digital back end of an 8-bit flash converter with apb control registers
// assumes ain is a digitised input level synchronous to pclk; values
// of 256 and above lie over the top reference
// Functional notes
// [RQ1] overrange drives flag and all data high
// [RQ2] 256 comparators, equally spaced reference levels
// [RQ3] comparators track input while clock low
// [RQ4] rising edge latches thermometer code
// [RQ5] falling edge registers four 64-to-6 decoders
// [RQ6] four 7-bit column latches track falling
// [RQ7] column contents low six, column index top
// [RQ8] eight xor gates before output latches
// [RQ9] eight output latches drive data pins
// [RQ10] one clock from sample to output
// [RQ11] low control inverts seven lower bits
// [RQ12] msb control inverts only top bit
// [RQ13] controls default low: straight binary
// [RQ14] valid flag toggles with valid output data
// [RQ15] polarity control selects flag polarity
// [RQ16] user picks binary or two's complement
// [RQ17] pipeline has no reset, fills by clocking
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module fadc_backend
    import fadc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [AIN_W-1:0] ain,
    output logic sample_bit_lowest,
    output logic [5:0] sample_bits_middle,
    output logic sample_bit_highest,
    output logic overrange_bit,
    output logic sample_valid_flag,
    output logic irq
);
    logic [NUM_COMP-1:0] comp_d;
    logic [NUM_COMP-1:0] therm_q;
    logic [NUM_COMP-1:0] tt;
    fadc_col_t [NUM_SEG-1:0] col_d;
    fadc_col_t [NUM_SEG-1:0] col_q;
    logic ovr_n_q;
    fadc_code_t straight;
    fadc_code_t coded_d;
    fadc_code_t out_q;
    logic [CODE_W-1:0] last_straight_q;
    logic [1:0] fill_q;
    logic filled;
    logic rise_q;
    logic fall_q;
    fadc_ctl_t ctrl_q;
    fadc_ctl_t ctrl_wr;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] status_d;
    logic [EVT_W-1:0] evt;
    logic apb_access;
    logic capture;
    logic apb_done;
    logic ack_q;
    logic err_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_last;
    logic mapped;
    logic stat_rd;

    // comparator i goes high once the input reaches level i+1
    always_comb
    begin
        for (int i = 0; i < NUM_COMP; i++)
        begin
            comp_d[i] = (ain >= AIN_W'(i + 1)); // [RQ2] [RQ3]
        end
    end

    // pipeline stages carry no reset; they fill by clocking
    always_ff @(posedge pclk)
    begin
        therm_q <= comp_d; // [RQ4] [RQ17]
    end

    // top comparator is the overrange line; line 0 stands for level zero
    assign tt = {therm_q[NUM_COMP-2:0], 1'b1};

    generate
        for (genvar s = 0; s < NUM_SEG; s++)
        begin : g_seg
            fadc_seg_decoder u_dec (
                .seg(tt[s*SEG_W +: SEG_W]),
                .col(col_d[s])
            );
        end
    endgenerate

    always_ff @(negedge pclk)
    begin
        col_q <= col_d; // [RQ5] [RQ6]
        ovr_n_q <= therm_q[NUM_COMP-1]; // [RQ1]
    end

    // the highest column holding ones names the two msbs
    function automatic fadc_code_t combine(input fadc_col_t [NUM_SEG-1:0] cols,
                                           input logic ovr);
        fadc_code_t r;
        r.ovr = ovr;
        r.data = 8'h00;
        for (int s = 0; s < NUM_SEG; s++)
        begin
            if (cols[s].any)
            begin
                r.data = {2'(s), cols[s].idx};
            end
        end
        return r;
    endfunction

    assign straight = combine(col_q, ovr_n_q); // [RQ7]

    fadc_out_stage u_out (
        .pclk(pclk),
        .straight(straight),
        .ctl(ctrl_q),
        .coded_d(coded_d),
        .out_q(out_q)
    );

    assign sample_bit_lowest = out_q.data[0]; // [RQ9]
    assign sample_bits_middle = out_q.data[6:1];
    assign sample_bit_highest = out_q.data[7];
    assign overrange_bit = out_q.ovr; // [RQ1]

    always_ff @(posedge pclk)
    begin
        last_straight_q <= straight.data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fill_q <= 2'h0;
        end
        else if (fill_q != FILL_FULL)
        begin
            fill_q <= fill_q + 2'h1; // [RQ17]
        end
    end

    assign filled = (fill_q == FILL_FULL);

    // flag is active (high when pol is clear, low when it is set) in the first half cycle after each output update once the pipe is filled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rise_q <= 1'b0;
        end
        else
        begin
            rise_q <= ~rise_q;
        end
    end

    always_ff @(negedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fall_q <= 1'b0;
        end
        else
        begin
            fall_q <= rise_q;
        end
    end

    assign sample_valid_flag = (filled & (rise_q ^ fall_q)) ^ ctrl_q.pol; // [RQ14] [RQ15]

    // apb: one wait state, read data and error come from flops
    assign apb_access = psel & penable;
    assign capture = apb_access & ~ack_q;
    assign apb_done = apb_access & ack_q;
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_stat = (paddr == ADDR_STATUS);
    assign hit_mask = (paddr == ADDR_MASK);
    assign hit_last = (paddr == ADDR_LAST);
    assign mapped = hit_ctrl | hit_stat | hit_mask | hit_last;
    // status clears when it is captured, so an event on the clearing edge survives
    assign stat_rd = capture & ~pwrite & hit_stat;

    always_comb
    begin
        rd_mux = RDATA_ZERO;
        case (1'b1)
            hit_ctrl: rd_mux[CTRL_W-1:0] = ctrl_q;
            hit_stat: rd_mux[EVT_W-1:0] = status_q;
            hit_mask: rd_mux[EVT_W-1:0] = mask_q;
            hit_last: rd_mux[CODE_W:0] = out_q;
            default: rd_mux = RDATA_ZERO;
        endcase
    end

    assign ctrl_wr.low_inv = pwdata[CTRL_LOW_BIT];
    assign ctrl_wr.msb_inv = pwdata[CTRL_MSB_BIT];
    assign ctrl_wr.pol = pwdata[CTRL_POL_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            prdata_q <= RDATA_ZERO;
        end
        else
        begin
            ack_q <= capture;
            if (capture)
            begin
                err_q <= ~mapped;
                prdata_q <= pwrite ? RDATA_ZERO : rd_mux;
            end
        end
    end

    assign pready = ack_q;
    assign pslverr = ack_q & err_q;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST; // [RQ13]
            mask_q <= MASK_RST;
        end
        else if (apb_done & pwrite)
        begin
            if (hit_ctrl)
            begin
                ctrl_q <= ctrl_wr; // [RQ16]
            end
            if (hit_mask)
            begin
                mask_q <= pwdata[EVT_W-1:0];
            end
        end
    end

    assign evt[EVT_OVR_BIT] = (fill_q != 2'h0) & straight.ovr;
    assign evt[EVT_CHG_BIT] = filled & (straight.data != last_straight_q);
    assign status_d = (status_q & ~{EVT_W{stat_rd}}) | evt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= STATUS_RST;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    assign irq = |(status_q & mask_q);

    // helper history for the checks below
    logic [AIN_W-1:0] ain_h1_q;
    logic [AIN_W-1:0] ain_h2_q;
    fadc_ctl_t ctl_h_q;

    always_ff @(posedge pclk)
    begin
        ain_h1_q <= ain;
        ain_h2_q <= ain_h1_q;
        ctl_h_q <= ctrl_q;
    end

    AST_OVR_ALL_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
        filled && ain_h2_q[8] |-> overrange_bit && out_q.data == OVR_CODE)
        else $error("overrange did not force all outputs high");

    AST_STRAIGHT_LATENCY: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
        filled && ctl_h_q == CTRL_RST && !ain_h2_q[8]
        |-> !overrange_bit && out_q.data == ain_h2_q[7:0])
        else $error("output code not the input one cycle later");

    AST_LOW_INV: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
        filled && ctl_h_q.low_inv && !ctl_h_q.msb_inv && !ain_h2_q[8]
        |-> out_q.data == {ain_h2_q[7], ~ain_h2_q[6:0]})
        else $error("low inversion wrong");

    AST_MSB_INV: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
        filled && ctl_h_q.msb_inv && !ctl_h_q.low_inv && !ain_h2_q[8]
        |-> out_q.data == {~ain_h2_q[7], ain_h2_q[6:0]})
        else $error("msb inversion wrong");

    AST_BOTH_INV: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11] [RQ12]
        filled && ctl_h_q.msb_inv && ctl_h_q.low_inv && !ain_h2_q[8]
        |-> out_q.data == ~ain_h2_q[7:0])
        else $error("full inversion wrong");

    AST_THERMO: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
        fill_q != 2'h0 |-> ((therm_q >> 1) & ~therm_q) == '0)
        else $error("latched comparators are not a thermometer code");

    AST_FLAG_SAMPLE_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
        ##1 1'b1 |-> sample_valid_flag == ctrl_q.pol)
        else $error("valid flag wrong before rising edge");

    AST_FLAG_VALID_PHASE: assert property (@(negedge pclk) disable iff (!presetn) // [RQ14]
        filled && $stable(ctrl_q) |-> ##1 sample_valid_flag == ~ctrl_q.pol)
        else $error("valid flag did not mark new data");

    AST_OVR_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
        filled && overrange_bit |-> status_q[EVT_OVR_BIT])
        else $error("overrange event not recorded");

    AST_READ_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        stat_rd && evt == 2'h0 |=> status_q == 2'h0 && pready)
        else $error("status read did not clear");

    AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");

    // unmapped offsets must answer with an error and read as zero
    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        capture && !mapped |=> pready && pslverr && prdata == RDATA_ZERO)
        else $error("unmapped access not refused");

    // coding must start as straight binary with nothing unmasked
    AST_CTRL_DEFAULT: assert property (@(posedge pclk) // [RQ13]
        $rose(presetn) |-> ctrl_q == CTRL_RST && mask_q == MASK_RST)
        else $error("controls not at default after reset");
endmodule

// ### fadc_capture.sv
// downstream capture model: latches each sample while the valid flag is active
// assumes the flag is active from a rising edge to the next falling edge
`timescale 1ns/100ps
module fadc_capture
    import fadc_pkg::*;
(
    input wire logic pclk,
    input wire logic sample_valid_flag,
    input wire logic pol,
    input fadc_code_t code,
    output fadc_code_t cap_q,
    output int cap_count
);
    initial cap_count = 0;
    // flag is read before the falling edge updates it, so the active phase is seen
    always @(negedge pclk)
    begin
        if (sample_valid_flag === ~pol)
        begin
            cap_q <= code;
            cap_count <= cap_count + 1;
        end
    end
endmodule

// ### flash_adc_digital_backend_test.sv
// self-checking bench for the flash converter back end
// assumes the apb slave answers with one wait state and a 1 clock sample latency
`timescale 1ns/100ps
module flash_adc_digital_backend_test;
    import fadc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, flag, pol;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [AIN_W-1:0] ain;
    logic [5:0] mid;
    logic lo, hi, ovr, err;
    fadc_code_t pins, cap;
    int cap_count, n_errors, checks, cycles, n0;
    assign pins = {ovr, hi, mid, lo};

    fadc_backend DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ain(ain), .sample_bit_lowest(lo),
        .sample_bits_middle(mid), .sample_bit_highest(hi), .overrange_bit(ovr),
        .sample_valid_flag(flag), .irq(irq));
    fadc_capture cap_model (.pclk(pclk), .sample_valid_flag(flag), .pol(pol), .code(pins),
        .cap_q(cap), .cap_count(cap_count));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // request held from setup until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // the wait ends when pready is seen high; the cycle ceiling stops it only if pready never comes
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [8:0] expect_code(input logic [AIN_W-1:0] a, input logic [2:0] c);
        logic [7:0] m;
        m = (c[CTRL_LOW_BIT] ? LOW_INV_MASK : 8'h00) ^ (c[CTRL_MSB_BIT] ? MSB_INV_MASK : 8'h00);
        if (a >= 9'h100)
            return {1'b1, OVR_CODE};
        return {1'b0, a[7:0] ^ m};
    endfunction

    task automatic sample_check(input logic [AIN_W-1:0] a, input logic [2:0] c);
        @(posedge pclk);
        ain <= a;
        repeat (2) @(posedge pclk);
        #1;
        check(32'(pins), 32'(expect_code(a, c)));
    endtask

    task automatic test_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b0, ADDR_MASK, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0000_0007);
        apb(1'b1, ADDR_CTRL, 32'h0);
        $display("test regs done");
    endtask

    task automatic test_codes();
        logic [AIN_W-1:0] vals[9] = '{0, 1, 63, 64, 127, 128, 191, 192, 255};
        foreach (vals[i])
            sample_check(vals[i], 3'h0);
        @(posedge pclk);
        ain <= 9'h00A;
        @(posedge pclk);
        ain <= 9'h014;
        @(posedge pclk);
        ain <= 9'h01E;
        #1;
        check(32'(pins), 32'h0000_000A);
        @(posedge pclk);
        #1;
        check(32'(pins), 32'h0000_0014);
        $display("test codes done");
    endtask

    task automatic test_modes();
        logic [7:0] vals[4] = '{8'h00, 8'h55, 8'h80, 8'hFE};
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, ADDR_CTRL, 32'(c));
            foreach (vals[i])
                sample_check({1'b0, vals[i]}, 3'(c));
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
        sample_check(9'h100, 3'h0);
        sample_check(9'h1FF, 3'h0);
        apb(1'b0, ADDR_LAST, 32'h0);
        check(rd, 32'h0000_01FF);
        $display("test modes done");
    endtask

    task automatic test_irq();
        apb(1'b1, ADDR_MASK, 32'h1);
        sample_check(9'h005, 3'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'({rd[1:0], irq}), 32'h0000_0000);
        sample_check(9'h100, 3'h0);
        sample_check(9'h005, 3'h0);
        check(32'(irq), 32'h0000_0001);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd[0]), 32'h0000_0001);
        @(posedge pclk);
        #1;
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, ADDR_MASK, 32'h0);
        sample_check(9'h100, 3'h0);
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, ADDR_MASK, 32'h2);
        sample_check(9'h033, 3'h0);
        check(32'(irq), 32'h0000_0001);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd[1]), 32'h0000_0001);
        $display("test irq done");
    endtask

    task automatic test_flag();
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, ADDR_CTRL, 32'(p << CTRL_POL_BIT));
            pol = 1'(p);
            repeat (2) @(posedge pclk);
            #1;
            check(32'(flag), 32'(!pol));
            @(negedge pclk);
            #1;
            check(32'(flag), 32'(pol));
            n0 = cap_count;
            repeat (3) @(negedge pclk);
            #1;
            check(32'(cap_count - n0), 32'h0000_0003);
            check(32'(cap), 32'(expect_code(ain, 3'h0)));
        end
        $display("test flag done");
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ain = 9'h000;
        pol = 1'b0;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_codes();
        test_modes();
        test_irq();
        test_flag();
        report_and_stop();
    end
endmodule
